// >>> design/xmi_defs.svh
/*
 * Constants of the external memory interface: mode encodings, field positions,
 * reset values and fixed cycle counts.
 * Assumes inclusion by bare name from the design files of this block only.
 */
`ifndef XMI_DEFS_SVH
`define XMI_DEFS_SVH

// ==========================================================================
// Memory mode field encodings
// ==========================================================================
`define XMI_MODE_ONCHIP     2'h0
`define XMI_MODE_SPLIT_NB   2'h1
`define XMI_MODE_SPLIT_BANK 2'h2
`define XMI_MODE_OFFCHIP    2'h3

// ==========================================================================
// On-chip memory size and boundary
// ==========================================================================
`define XMI_ON_CHIP_EXTERNAL_RAM_AW         12
`define XMI_BOUNDARY        16'h1000
`define XMI_PAGE_MSB        4

// ==========================================================================
// Timing register fields and reset value
// ==========================================================================
`define XMI_TIM_SETUP_MSB   7
`define XMI_TIM_SETUP_LSB   6
`define XMI_TIM_STRB_MSB    5
`define XMI_TIM_STRB_LSB    2
`define XMI_TIM_HOLD_MSB    1
`define XMI_TIM_HOLD_LSB    0
`define XMI_TIM_RST         8'hFF

// ==========================================================================
// Fixed cycle counts
// ==========================================================================
`define XMI_OVERHEAD        4
`define XMI_ALE_EXTRA       1

`endif

// >>> design/xmi_pkg.sv
/*
 * Types shared by the external memory interface design files.
 * Assumes the constants of xmi_defs.svh are available separately.
 */
package xmi_pkg;

    // ======================================================================
    // Access sequencer states
    // ======================================================================
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ONCHIP,
        ST_START,
        ST_ALE,
        ST_GAP,
        ST_ADDR,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_FINISH,
        ST_DONE
    } xmi_state_type;

endpackage : xmi_pkg

// >>> design/xmi_phase_timer.sv
/*
 * Down counter that times one phase of an off-chip access.
 * Assumes an asynchronous active-low reset whose release is already synchronised to core_clk.
 */
`timescale 1ns/1ps

module xmi_phase_timer #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    // Status
    output logic                  zero
);

    logic [WIDTH-1:0] count_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= load_val;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    assign zero = (count_q == '0);

endmodule : xmi_phase_timer

// >>> design/xmi_top.sv
/*
 * External memory interface: routes external moves to on-chip memory or to
 * off-chip devices over shared port pins, with programmable phase timing.
 * Assumes the CPU holds a request until it is taken and that the port logic
 * outside muxes each pin group by its claim signal and applies output modes.
 */
`timescale 1ns/1ps
`include "xmi_defs.svh"

module xmi_top #(
    parameter int ON_CHIP_EXTERNAL_RAM_AW = `XMI_ON_CHIP_EXTERNAL_RAM_AW
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Configuration
    input  wire logic [4:0]  page_select_field,
    input  wire logic [1:0]  memory_mode_field,
    input  wire logic [1:0]  latch_pulse_width_field,
    input  wire logic        mux_mode,
    input  wire logic        timing_wr_en,
    input  wire logic [7:0]  timing_wr_data,
    output logic      [7:0]  timing_rd_data,
    // CPU move request
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic        req_wide,
    input  wire logic [15:0] req_data_pointer_pair,
    input  wire logic [7:0]  req_index,
    input  wire logic [7:0]  req_wdata,
    output logic             busy,
    output logic             done,
    output logic      [7:0]  rdata,
    // Upper address pins
    output logic      [3:0]  addr_hi_out,
    output logic             addr_hi_claim,
    // Low address pins, non-multiplexed mode
    output logic      [7:0]  addr_lo_out,
    output logic             addr_lo_claim,
    // Data or address-data pins
    input  wire logic [7:0]  ad_in,
    output logic      [7:0]  ad_out,
    output logic             ad_claim,
    output logic             ad_drv_off,
    // Strobes
    output logic             ale_out,
    output logic             ale_claim,
    output logic             rd_n_out,
    output logic             wr_n_out,
    output logic             strobe_claim
);

    // ======================================================================
    // Reset release
    // ======================================================================
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ======================================================================
    // Timing register
    // ======================================================================
    logic [7:0] tim_q;
    logic [1:0] tim_setup;
    logic [3:0] tim_strobe;
    logic [1:0] tim_hold;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tim_q <= `XMI_TIM_RST;
        end else if (timing_wr_en) begin
            tim_q <= timing_wr_data;
        end
    end

    assign tim_setup  = tim_q[`XMI_TIM_SETUP_MSB:`XMI_TIM_SETUP_LSB];
    assign tim_strobe = tim_q[`XMI_TIM_STRB_MSB:`XMI_TIM_STRB_LSB];
    assign tim_hold   = tim_q[`XMI_TIM_HOLD_MSB:`XMI_TIM_HOLD_LSB];
    assign timing_rd_data = tim_q;

    // ======================================================================
    // Address formation and routing
    // ======================================================================
    logic [15:0] eff_addr;
    logic        go_off;
    logic        drive_hi;
    logic        take;

    assign take     = req_valid && !busy;
    assign eff_addr = req_wide ? req_data_pointer_pair : {3'h0, page_select_field, req_index};

    always_comb begin
        case (memory_mode_field)
            `XMI_MODE_ONCHIP: begin
                go_off = 1'b0;
            end
            `XMI_MODE_OFFCHIP: begin
                go_off = 1'b1;
            end
            default: begin
                // For 8-bit moves this is exactly the page field top bit.
                go_off = (eff_addr >= `XMI_BOUNDARY);
            end
        endcase
        drive_hi = req_wide || (memory_mode_field == `XMI_MODE_SPLIT_BANK);
    end

    logic [11:0] addr_q;
    logic        write_q;
    logic        hi_en_q;
    logic        wide_q;
    logic [1:0]  mode_q;
    logic [7:0]  wdata_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q  <= 12'h000;
            write_q <= 1'b0;
            hi_en_q <= 1'b0;
            wide_q  <= 1'b0;
            mode_q  <= `XMI_MODE_ONCHIP;
            wdata_q <= 8'h00;
        end else if (take) begin
            addr_q  <= eff_addr[11:0];
            write_q <= req_write;
            hi_en_q <= drive_hi;
            wide_q  <= req_wide;
            mode_q  <= memory_mode_field;
            wdata_q <= req_wdata;
        end
    end

    // ======================================================================
    // On-chip memory
    // ======================================================================
    logic [7:0] on_chip_external_ram_mem [0:(1<<ON_CHIP_EXTERNAL_RAM_AW)-1];
    logic [7:0] on_chip_external_ram_rd;

    always_ff @(posedge core_clk) begin
        if (take && !go_off && req_write) begin
            on_chip_external_ram_mem[eff_addr[ON_CHIP_EXTERNAL_RAM_AW-1:0]] <= req_wdata;
        end
    end

    assign on_chip_external_ram_rd = on_chip_external_ram_mem[addr_q[ON_CHIP_EXTERNAL_RAM_AW-1:0]];

    // ======================================================================
    // Access sequencer
    // ======================================================================
    xmi_pkg::xmi_state_type state_q;
    xmi_pkg::xmi_state_type state_d;
    logic                   tmr_load;
    logic [3:0]             tmr_val;
    logic                   tmr_zero;

    xmi_phase_timer #(.WIDTH(4)) u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .zero     (tmr_zero)
    );

    always_comb begin
        state_d  = state_q;
        tmr_load = 1'b0;
        tmr_val  = 4'h0;
        case (state_q)
            xmi_pkg::ST_IDLE: begin
                if (take) begin
                    state_d = go_off ? xmi_pkg::ST_START : xmi_pkg::ST_ONCHIP;
                end
            end
            xmi_pkg::ST_ONCHIP: begin
                state_d = xmi_pkg::ST_IDLE;
            end
            xmi_pkg::ST_START: begin
                if (mux_mode) begin
                    state_d  = xmi_pkg::ST_ALE;
                    tmr_load = 1'b1;
                    tmr_val  = {2'h0, latch_pulse_width_field};
                end else begin
                    state_d = xmi_pkg::ST_ADDR;
                end
            end
            xmi_pkg::ST_ALE: begin
                if (tmr_zero) begin
                    state_d = xmi_pkg::ST_GAP;
                end
            end
            xmi_pkg::ST_GAP: begin
                state_d = xmi_pkg::ST_ADDR;
            end
            xmi_pkg::ST_ADDR: begin
                tmr_load = 1'b1;
                if (tim_setup != 2'h0) begin
                    state_d = xmi_pkg::ST_SETUP;
                    tmr_val = {2'h0, tim_setup - 2'h1};
                end else begin
                    state_d = xmi_pkg::ST_STROBE;
                    tmr_val = tim_strobe;
                end
            end
            xmi_pkg::ST_SETUP: begin
                if (tmr_zero) begin
                    state_d  = xmi_pkg::ST_STROBE;
                    tmr_load = 1'b1;
                    tmr_val  = tim_strobe;
                end
            end
            xmi_pkg::ST_STROBE: begin
                if (tmr_zero) begin
                    if (tim_hold != 2'h0) begin
                        state_d  = xmi_pkg::ST_HOLD;
                        tmr_load = 1'b1;
                        tmr_val  = {2'h0, tim_hold - 2'h1};
                    end else begin
                        state_d = xmi_pkg::ST_FINISH;
                    end
                end
            end
            xmi_pkg::ST_HOLD: begin
                if (tmr_zero) begin
                    state_d = xmi_pkg::ST_FINISH;
                end
            end
            xmi_pkg::ST_FINISH: begin
                state_d = xmi_pkg::ST_DONE;
            end
            xmi_pkg::ST_DONE: begin
                state_d = xmi_pkg::ST_IDLE;
            end
            default: begin
                state_d = xmi_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= xmi_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ======================================================================
    // Pin drive, registered from the next state so pins line up with it
    // ======================================================================
    logic        off_d;
    logic        addr_phase_d;
    logic [11:0] addr_d;
    logic        write_d;
    logic        hi_en_d;
    logic [7:0]  wdata_d;

    assign off_d = (state_d != xmi_pkg::ST_IDLE) && (state_d != xmi_pkg::ST_ONCHIP);
    assign addr_phase_d = mux_mode &&
                          ((state_d == xmi_pkg::ST_START) || (state_d == xmi_pkg::ST_ALE));
    // The capture registers load on the take edge itself, so the first pin cycle
    // of an access must see this request's values, not those of the last access.
    assign addr_d  = take ? eff_addr[11:0] : addr_q;
    assign write_d = take ? req_write : write_q;
    assign hi_en_d = take ? drive_hi : hi_en_q;
    assign wdata_d = take ? req_wdata : wdata_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_hi_claim <= 1'b0;
            addr_lo_claim <= 1'b0;
            ad_claim      <= 1'b0;
            ale_claim     <= 1'b0;
            strobe_claim  <= 1'b0;
            ad_drv_off    <= 1'b0;
        end else begin
            addr_hi_claim <= off_d && hi_en_d;
            addr_lo_claim <= off_d && !mux_mode;
            ad_claim      <= off_d;
            ale_claim     <= off_d && mux_mode;
            strobe_claim  <= off_d;
            // Input pins go high impedance; output pins are left to port mode.
            ad_drv_off    <= off_d && !write_d && !addr_phase_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_hi_out <= 4'h0;
            addr_lo_out <= 8'h00;
            ad_out      <= 8'h00;
            ale_out     <= 1'b0;
            rd_n_out    <= 1'b1;
            wr_n_out    <= 1'b1;
        end else begin
            addr_hi_out <= addr_d[11:8];
            addr_lo_out <= addr_d[7:0];
            ad_out      <= addr_phase_d ? addr_d[7:0] : wdata_d;
            ale_out     <= mux_mode && (state_d == xmi_pkg::ST_ALE);
            rd_n_out    <= !((state_d == xmi_pkg::ST_STROBE) && !write_q);
            wr_n_out    <= !((state_d == xmi_pkg::ST_STROBE) && write_q);
        end
    end

    // ======================================================================
    // Completion and read data
    // ======================================================================
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy  <= 1'b0;
            done  <= 1'b0;
            rdata <= 8'h00;
        end else begin
            busy <= (state_d != xmi_pkg::ST_IDLE);
            done <= (state_q == xmi_pkg::ST_ONCHIP) || (state_q == xmi_pkg::ST_DONE);
            if (state_q == xmi_pkg::ST_ONCHIP && !write_q) begin
                rdata <= on_chip_external_ram_rd;
            end else if (state_q == xmi_pkg::ST_STROBE && tmr_zero && !write_q) begin
                rdata <= ad_in;
            end
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] len_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            len_q <= 8'h00;
        end else if (state_q == xmi_pkg::ST_IDLE || state_q == xmi_pkg::ST_ONCHIP) begin
            len_q <= 8'h00;
        end else begin
            len_q <= len_q + 8'h01;
        end
    end

    chk_claim_idle_free: assert property (
        (state_q == xmi_pkg::ST_IDLE) |-> !ad_claim && !strobe_claim && !addr_hi_claim)
        else $error("pins claimed while idle");
    chk_read_drv_off: assert property (
        !rd_n_out |-> ad_drv_off && ad_claim)
        else $error("data drivers on during read strobe");
    chk_mode0_onchip: assert property (
        take && memory_mode_field == `XMI_MODE_ONCHIP |=> state_q == xmi_pkg::ST_ONCHIP)
        else $error("mode 00 move went off-chip");
    chk_mode3_offchip: assert property (
        take && memory_mode_field == `XMI_MODE_OFFCHIP |=> state_q == xmi_pkg::ST_START)
        else $error("mode 11 move stayed on-chip");
    chk_hi_undriven: assert property (
        ad_claim && !wide_q && mode_q != `XMI_MODE_SPLIT_BANK |-> !addr_hi_claim)
        else $error("upper lines driven by unbanked 8-bit move");
    chk_hi_value: assert property (
        addr_hi_claim |-> addr_hi_out == addr_q[11:8])
        else $error("upper address lines wrong");
    chk_ale_address: assert property (
        ale_out |-> ad_out == addr_q[7:0] ##1 (rd_n_out && wr_n_out))
        else $error("latch strobe phase without address");
    // The strobe field holds the width less one, and the count is zero in the first cycle.
    chk_access_length: assert property (
        state_q == xmi_pkg::ST_DONE |-> len_q == 8'(tim_setup + tim_strobe + 1 + tim_hold
            + `XMI_OVERHEAD - 1 + (mux_mode ? latch_pulse_width_field + 2 : 0)))
        else $error("off-chip access length wrong");
    chk_onchip_quiet: assert property (
        state_q == xmi_pkg::ST_ONCHIP |-> !ad_claim && !strobe_claim && rd_n_out && wr_n_out)
        else $error("on-chip access touched pins");

    cov_onchip_read: cover property (take && !go_off && !req_write ##1 state_q == xmi_pkg::ST_ONCHIP);
    cov_mux_write: cover property (ale_out && write_q ##[1:40] !wr_n_out);
    cov_bank_read: cover property (addr_hi_claim && !wide_q && !rd_n_out);

endmodule : xmi_top

// >>> testbench/xmi_sram_model.sv
/*
 * Behavioural off-chip byte memory on the external memory pins.
 * Assumes twelve address lines; upper lines not claimed float to the parked latch value.
 */
`timescale 1ns/1ps

module xmi_sram_model #(
    parameter logic [3:0] PARK_HI = 4'hF
) (
    // Clock
    input  wire logic       core_clk,
    // Pins from the interface
    input  wire logic       mux_mode,
    input  wire logic [3:0] addr_hi_out,
    input  wire logic       addr_hi_claim,
    input  wire logic [7:0] addr_lo_out,
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_drv_off,
    input  wire logic       ale_out,
    input  wire logic       rd_n_out,
    input  wire logic       wr_n_out,
    // Data back to the interface
    output logic      [7:0] ad_in
);
    logic [7:0]  mem [0:4095];
    logic [7:0]  lat_q  = 8'h00;
    logic [7:0]  last_q = 8'h00;
    logic [11:0] addr;

    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'h00;
        end
    end

    assign addr = {addr_hi_claim ? addr_hi_out : PARK_HI, mux_mode ? lat_q : addr_lo_out};

    always @(posedge core_clk) begin
        if (ale_out) begin
            lat_q <= ad_out;
        end
        if (!wr_n_out) begin
            mem[addr] <= ad_out;
        end
        if (!rd_n_out) begin
            last_q <= mem[addr];
        end
    end

    // A driver left on would fight the memory, so the read only lands with it off.
    assign ad_in = (!rd_n_out && ad_drv_off) ? mem[addr] : ~last_q;
endmodule : xmi_sram_model

// >>> testbench/test_external_memory_interface.sv
/*
 * Self-checking bench for xmi_top: table of moves, then reset and timing cases.
 * Assumes xmi_sram_model stands on the pins with upper lines parked at 4'hF.
 */
`timescale 1ns/1ps

module test_external_memory_interface;
    typedef struct packed {
        logic [1:0]  md;
        logic        mx, wr, wd;
        logic [15:0] dp;
        logic [7:0]  ix, pg, dat;
        logic        off, hic;
        logic [11:0] ea;
    } xmi_row_type;

    // ======================================================================
    // Signals and instances
    // ======================================================================
    logic core_clk = 1'b0, arst_n = 1'b0;
    logic [4:0] page_select_field = '0;
    logic [1:0] memory_mode_field = '0, latch_pulse_width_field = 2'h3;
    logic mux_mode = 1'b0, timing_wr_en = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic req_wide = 1'b0, busy, done, addr_hi_claim, addr_lo_claim, ad_claim, ad_drv_off;
    logic ale_out, ale_claim, rd_n_out, wr_n_out, strobe_claim;
    logic [7:0] timing_wr_data = '0, timing_rd_data, req_index = '0, req_wdata = '0;
    logic [7:0] rdata, addr_lo_out, ad_in, ad_out;
    logic [15:0] req_data_pointer_pair = '0;
    logic [3:0] addr_hi_out;
    int err_count = 0, n_tests = 0, cycles = 0, st = 3, sw = 15, ho = 3;

    xmi_top dut (.core_clk(core_clk), .arst_n(arst_n), .page_select_field(page_select_field),
        .memory_mode_field(memory_mode_field), .latch_pulse_width_field(latch_pulse_width_field),
        .mux_mode(mux_mode), .timing_wr_en(timing_wr_en), .timing_wr_data(timing_wr_data),
        .timing_rd_data(timing_rd_data), .req_valid(req_valid), .req_write(req_write),
        .req_wide(req_wide), .req_data_pointer_pair(req_data_pointer_pair), .req_index(req_index),
        .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata),
        .addr_hi_out(addr_hi_out), .addr_hi_claim(addr_hi_claim), .addr_lo_out(addr_lo_out),
        .addr_lo_claim(addr_lo_claim), .ad_in(ad_in), .ad_out(ad_out), .ad_claim(ad_claim),
        .ad_drv_off(ad_drv_off), .ale_out(ale_out), .ale_claim(ale_claim),
        .rd_n_out(rd_n_out), .wr_n_out(wr_n_out), .strobe_claim(strobe_claim));

    xmi_sram_model mem_model (.core_clk(core_clk), .mux_mode(mux_mode),
        .addr_hi_out(addr_hi_out), .addr_hi_claim(addr_hi_claim), .addr_lo_out(addr_lo_out),
        .ad_out(ad_out), .ad_drv_off(ad_drv_off), .ale_out(ale_out), .rd_n_out(rd_n_out),
        .wr_n_out(wr_n_out), .ad_in(ad_in));

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    // ======================================================================
    // Checking and closing
    // ======================================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic set_timing(input logic [7:0] v);
        @(posedge core_clk);
        timing_wr_en   <= 1'b1;
        timing_wr_data <= v;
        @(posedge core_clk);
        timing_wr_en <= 1'b0;
        st = v[7:6];
        sw = v[5:2];
        ho = v[1:0];
        @(posedge core_clk);
        #1 check("timing readback", timing_rd_data, v);
    endtask : set_timing

    // One move, watching every pin cycle by cycle until busy falls.
    task automatic run_row(input xmi_row_type r);
        int cyc = 0, lo_n = 0, ale_n = 0, own_n = 0, exp_cyc;
        logic hi = 1'b0, any = 1'b0, bad = 1'b0;
        logic [3:0] hv = 4'h0;
        exp_cyc = r.off ? st + sw + ho + 5 + (r.mx ? latch_pulse_width_field + 2 : 0) : 1;
        @(posedge core_clk);
        memory_mode_field <= r.md;
        mux_mode          <= r.mx;
        req_write         <= r.wr;
        req_wide          <= r.wd;
        req_data_pointer_pair          <= r.dp;
        req_index         <= r.ix;
        page_select_field <= r.pg[4:0];
        req_wdata         <= r.dat;
        req_valid         <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        #1;
        while (busy === 1'b1 && cyc < 100) begin
            cyc++;
            any |= ad_claim | strobe_claim | addr_lo_claim | ale_claim | addr_hi_claim;
            hi |= addr_hi_claim;
            if (addr_hi_claim) hv = addr_hi_out;
            if (!rd_n_out || !wr_n_out) lo_n++;
            if (ale_out) ale_n++;
            if (ad_claim && strobe_claim && addr_lo_claim != r.mx && ale_claim == r.mx
                    && addr_hi_claim == r.hic) own_n++;
            if ((!rd_n_out || !wr_n_out) && !r.mx && addr_lo_out !== r.ea[7:0]) bad = 1;
            if (!rd_n_out && (ad_drv_off !== 1'b1 || ale_out)) bad = 1;
            if (!wr_n_out && (ad_drv_off !== 1'b0 || ad_out !== r.dat || ale_out)) bad = 1;
            if (ale_out && (ad_out !== r.ea[7:0] || ad_drv_off)) bad = 1;
            @(posedge core_clk);
            #1;
        end
        check("busy cycles", cyc, exp_cyc);
        check("done pulse", done, 1);
        check("pins released", {ad_claim, strobe_claim, addr_lo_claim, ale_claim, addr_hi_claim}, 0);
        check("pins claimed", any, r.off);
        check("pins owned", own_n, r.off ? exp_cyc : 0);
        check("upper claim", hi, r.hic);
        if (r.off) begin
            check("strobe width", lo_n, sw + 1);
            check("pin phases", bad, 0);
            if (r.hic) check("upper address", hv, r.ea[11:8]);
            if (r.mx) check("latch width", ale_n, latch_pulse_width_field + 1);
            if (r.wr) check("off-chip byte", mem_model.mem[r.ea], r.dat);
        end
        if (!r.wr) check("read data", rdata, r.dat);
    endtask : run_row

    // ======================================================================
    // Ordinary moves: writes, and reads of earlier writes, across every mode
    // ======================================================================
    localparam xmi_row_type ROWS [14] = '{
        '{2'h0, 0, 1, 1, 16'h1005, 8'h00, 8'h00, 8'h5A, 0, 0, 12'h000},
        '{2'h0, 0, 0, 1, 16'h0005, 8'h00, 8'h00, 8'h5A, 0, 0, 12'h000},
        '{2'h0, 0, 1, 0, 16'h0000, 8'h10, 8'h02, 8'h33, 0, 0, 12'h000},
        '{2'h1, 0, 0, 0, 16'h0000, 8'h10, 8'h02, 8'h33, 0, 0, 12'h000},
        '{2'h1, 0, 1, 0, 16'h0000, 8'h34, 8'h12, 8'hC3, 1, 0, 12'hF34},
        '{2'h1, 0, 0, 0, 16'h0000, 8'h34, 8'h12, 8'hC3, 1, 0, 12'hF34},
        '{2'h2, 0, 1, 0, 16'h0000, 8'h21, 8'h13, 8'h96, 1, 1, 12'h321},
        '{2'h2, 0, 0, 1, 16'h1321, 8'h00, 8'h00, 8'h96, 1, 1, 12'h321},
        '{2'h1, 0, 1, 1, 16'h1ABC, 8'h00, 8'h00, 8'h0F, 1, 1, 12'hABC},
        '{2'h3, 0, 1, 1, 16'h0005, 8'h00, 8'h00, 8'hE1, 1, 1, 12'h005},
        '{2'h0, 0, 0, 1, 16'h0005, 8'h00, 8'h00, 8'h5A, 0, 0, 12'h000},
        '{2'h3, 0, 0, 0, 16'h0000, 8'h34, 8'h02, 8'hC3, 1, 0, 12'hF34},
        '{2'h3, 1, 1, 1, 16'h0777, 8'h00, 8'h00, 8'h6B, 1, 1, 12'h777},
        '{2'h2, 1, 0, 0, 16'h0000, 8'h77, 8'h17, 8'h6B, 1, 1, 12'h777}
    };

    initial begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check("timing after reset", timing_rd_data, 8'hFF);
        check("strobes idle", {rd_n_out, wr_n_out, ale_out, busy}, 4'hC);
        // At the reset timing a multiplexed write runs at full length.
        run_row('{2'h3, 1, 1, 1, 16'h0456, 8'h00, 8'h00, 8'h3C, 1, 1, 12'h456});
        @(posedge core_clk) latch_pulse_width_field <= 2'h0;
        set_timing(8'h00);
        foreach (ROWS[i]) begin
            run_row(ROWS[i]);
        end
        // Odd timing values read the same byte back without the latch.
        set_timing(8'h49);
        run_row('{2'h3, 0, 0, 1, 16'h0456, 8'h00, 8'h00, 8'h3C, 1, 1, 12'h456});
        // A reset in mid-run brings the timing back to its slowest setting.
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check("timing after second reset", timing_rd_data, 8'hFF);
        check("strobes after second reset", {rd_n_out, wr_n_out, ale_out, busy}, 4'hC);
        stop_test();
    end
endmodule : test_external_memory_interface
